// ===== design/counter_status_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - per-counter fault mask, four bits
// - 24-bit microsecond stamp, wrap flag per cycle
// - count wrap flag, false under auto direction
// - module output mask, six low and six
// - upper bits; overcurrent turns all outputs off
// - per-output fault mask, four bits
// - outputs follow the software value, each cut by its own live overcurrent trip
// - auto direction detects, else manual direction
module counter_status_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [counter_status_pkg::ADDR_W-1:0] paddr,
    input wire logic [counter_status_pkg::DATA_W-1:0] pwdata,
    output logic [counter_status_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter pins
    input wire logic [1:0] cnt_a,
    input wire logic [1:0] cnt_b,
    // fault sense pins
    input wire logic [7:0] counter_fault_in,
    input wire logic [15:0] module_fault_in,
    input wire logic [15:0] channel_fault_in,
    // outputs
    output logic [3:0] out_drive,
    output logic irq
);
    localparam int DW = counter_status_pkg::DATA_W;
    localparam int IW = counter_status_pkg::IRQ_W;

    function automatic logic [DW-1:0] word24(input logic [23:0] v);
        word24 = {8'h00, v};
    endfunction

    function automatic logic [7:0] nibble_mask(input logic [3:0] v);
        nibble_mask = {4'h0, v};
    endfunction

    counter_link_if link[2] ();

    // pin synchronisers
    logic [1:0] a_meta;
    logic [1:0] a_sync;
    logic [1:0] b_meta;
    logic [1:0] b_sync;
    logic [7:0] cf_meta;
    logic [7:0] cf_sync;
    logic [15:0] mf_meta;
    logic [15:0] mf_sync;
    logic [15:0] chf_meta;
    logic [15:0] chf_sync;

    // registers
    logic [1:0] auto_dir_enable;
    logic [1:0] manual_dir;
    logic snapshot;
    logic snapshot_d;
    logic [3:0] output_drive_value;
    logic [7:0] counter_fault_mask [2];
    logic [15:0] output_module_fault_mask;
    logic [7:0] output_channel_fault_mask [4];
    logic [IW-1:0] irq_status;
    logic [IW-1:0] irq_enable;

    // bus decode
    logic setup;
    logic wr_en;
    logic [IW-1:0] irq_clear;
    logic [IW-1:0] irq_events;
    logic [DW-1:0] next_prdata;
    logic next_pslverr;
    logic [3:0] chan_trip;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_meta <= 2'h0;
            a_sync <= 2'h0;
            b_meta <= 2'h0;
            b_sync <= 2'h0;
        end else begin
            a_meta <= cnt_a;
            a_sync <= a_meta;
            b_meta <= cnt_b;
            b_sync <= b_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cf_meta <= 8'h00;
            cf_sync <= 8'h00;
            mf_meta <= 16'h0000;
            mf_sync <= 16'h0000;
            chf_meta <= 16'h0000;
            chf_sync <= 16'h0000;
        end else begin
            cf_meta <= counter_fault_in;
            cf_sync <= cf_meta;
            mf_meta <= module_fault_in;
            mf_sync <= mf_meta;
            chf_meta <= channel_fault_in;
            chf_sync <= chf_meta;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            assign link[gi].auto_dir = auto_dir_enable[gi];
            assign link[gi].manual_dir = manual_dir[gi];
            assign link[gi].snapshot = snapshot;
            assign link[gi].in_a = a_sync[gi];
            assign link[gi].in_b = b_sync[gi];
            counter_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .link(link[gi])
            );
        end
    endgenerate

    // control register; the snapshot bit marks one controller cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_dir_enable <= counter_status_pkg::AUTO_DIR_RESET;
            manual_dir <= counter_status_pkg::MANUAL_DIR_RESET;
            snapshot <= 1'b0;
        end else begin
            snapshot <= wr_en && (paddr == counter_status_pkg::CTRL_OFS)
                && pwdata[counter_status_pkg::CTRL_SNAPSHOT_BIT];
            if (wr_en && (paddr == counter_status_pkg::CTRL_OFS)) begin
                auto_dir_enable <= pwdata[counter_status_pkg::CTRL_AUTO_DIR_LSB +: 2];
                manual_dir <= pwdata[counter_status_pkg::CTRL_MANUAL_DIR_LSB +: 2];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snapshot_d <= 1'b0;
        end else begin
            snapshot_d <= snapshot;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_drive_value <= counter_status_pkg::OUT_VALUE_RESET;
        end else if (wr_en && (paddr == counter_status_pkg::OUT_VALUE_OFS)) begin
            output_drive_value <= pwdata[3:0];
        end
    end

    // fault masks are captured once per controller cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_fault_mask[0] <= 8'h00;
            counter_fault_mask[1] <= 8'h00;
            output_module_fault_mask <= 16'h0000;
        end else if (snapshot) begin
            counter_fault_mask[0] <= nibble_mask(cf_sync[3:0]) & counter_status_pkg::CNT_FAULT_BITS;
            counter_fault_mask[1] <= nibble_mask(cf_sync[7:4]) & counter_status_pkg::CNT_FAULT_BITS;
            output_module_fault_mask <= mf_sync & counter_status_pkg::MOD_FAULT_BITS;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                output_channel_fault_mask[i] <= 8'h00;
            end
        end else if (snapshot) begin
            for (int i = 0; i < 4; i++) begin
                output_channel_fault_mask[i] <= nibble_mask(chf_sync[4*i +: 4])
                    & counter_status_pkg::CH_FAULT_BITS;
            end
        end
    end

    // live overcurrent trips cut the outputs at once; no counter path reaches them
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chan_trip[i] = chf_sync[4*i + counter_status_pkg::CH_OVERCURRENT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_drive <= 4'h0;
        end else if (mf_sync[counter_status_pkg::MOD_OVERCURRENT_BIT]) begin
            out_drive <= 4'h0;
        end else begin
            out_drive <= output_drive_value & ~chan_trip;
        end
    end

    // interrupt events, one cycle after the snapshot when the flags have settled
    always_comb begin
        irq_events = '0;
        if (snapshot_d) begin
            irq_events[counter_status_pkg::IRQ_COUNT_OVF_LSB] = link[0].count_ovf;
            irq_events[counter_status_pkg::IRQ_COUNT_OVF_LSB + 1] = link[1].count_ovf;
            irq_events[counter_status_pkg::IRQ_STAMP_OVF_LSB] = link[0].stamp_ovf;
            irq_events[counter_status_pkg::IRQ_STAMP_OVF_LSB + 1] = link[1].stamp_ovf;
            irq_events[counter_status_pkg::IRQ_CNT_FAULT_BIT] = |{counter_fault_mask[0], counter_fault_mask[1]};
            irq_events[counter_status_pkg::IRQ_MOD_FAULT_BIT] = |output_module_fault_mask;
            irq_events[counter_status_pkg::IRQ_CH_FAULT_BIT] = |{output_channel_fault_mask[0],
                output_channel_fault_mask[1], output_channel_fault_mask[2], output_channel_fault_mask[3]};
        end
    end

    assign irq_clear = (wr_en && (paddr == counter_status_pkg::IRQ_CLEAR_OFS)) ? pwdata[IW-1:0] : '0;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= counter_status_pkg::IRQ_ENABLE_RESET;
        end else if (wr_en && (paddr == counter_status_pkg::IRQ_ENABLE_OFS)) begin
            irq_enable <= pwdata[IW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // read mux, evaluated in the setup cycle and registered for the access cycle
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        case (paddr)
            counter_status_pkg::CTRL_OFS: begin
                next_prdata[counter_status_pkg::CTRL_AUTO_DIR_LSB +: 2] = auto_dir_enable;
                next_prdata[counter_status_pkg::CTRL_MANUAL_DIR_LSB +: 2] = manual_dir;
            end
            counter_status_pkg::OUT_VALUE_OFS: next_prdata = '0;
            counter_status_pkg::IRQ_STATUS_OFS: next_prdata[IW-1:0] = irq_status;
            counter_status_pkg::IRQ_CLEAR_OFS: next_prdata = '0;
            counter_status_pkg::IRQ_ENABLE_OFS: next_prdata[IW-1:0] = irq_enable;
            counter_status_pkg::COUNT0_OFS: next_prdata = word24(link[0].count);
            counter_status_pkg::COUNT1_OFS: next_prdata = word24(link[1].count);
            counter_status_pkg::STAMP0_OFS: next_prdata = word24(link[0].stamp);
            counter_status_pkg::STAMP1_OFS: next_prdata = word24(link[1].stamp);
            counter_status_pkg::CNT_FAULT_OFS: next_prdata[15:0] = {counter_fault_mask[1], counter_fault_mask[0]};
            counter_status_pkg::OVF_FLAGS_OFS: begin
                next_prdata[counter_status_pkg::OVF_COUNT_LSB +: 2] = {link[1].count_ovf, link[0].count_ovf};
                next_prdata[counter_status_pkg::OVF_STAMP_LSB +: 2] = {link[1].stamp_ovf, link[0].stamp_ovf};
            end
            counter_status_pkg::MODULE_FAULT_OFS: next_prdata[15:0] = output_module_fault_mask;
            counter_status_pkg::CHANNEL_FAULT_OFS: next_prdata = {output_channel_fault_mask[3],
                output_channel_fault_mask[2], output_channel_fault_mask[1], output_channel_fault_mask[0]};
            default: next_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? '0 : next_prdata;
                pslverr <= next_pslverr;
            end else begin
                prdata <= '0;
                pslverr <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/counter_status_pkg.sv
package counter_status_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 24;
    localparam int NUM_COUNTERS = 2;
    localparam int NUM_OUTPUTS = 4;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OUT_VALUE_OFS = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h0C;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h10;
    localparam logic [7:0] COUNT0_OFS = 8'h14;
    localparam logic [7:0] COUNT1_OFS = 8'h18;
    localparam logic [7:0] STAMP0_OFS = 8'h1C;
    localparam logic [7:0] STAMP1_OFS = 8'h20;
    localparam logic [7:0] CNT_FAULT_OFS = 8'h24;
    localparam logic [7:0] OVF_FLAGS_OFS = 8'h28;
    localparam logic [7:0] MODULE_FAULT_OFS = 8'h2C;
    localparam logic [7:0] CHANNEL_FAULT_OFS = 8'h30;

    // control register fields
    localparam int CTRL_SNAPSHOT_BIT = 0;
    localparam int CTRL_AUTO_DIR_LSB = 1;
    localparam int CTRL_MANUAL_DIR_LSB = 3;

    // overflow flag register fields
    localparam int OVF_COUNT_LSB = 0;
    localparam int OVF_STAMP_LSB = 2;

    // counter fault mask bits
    localparam logic [7:0] CNT_FAULT_UNIT = 8'h01;
    localparam logic [7:0] CNT_FAULT_COUNT_CMP = 8'h02;
    localparam logic [7:0] CNT_FAULT_STAMP_CMP = 8'h04;
    localparam logic [7:0] CNT_FAULT_RESET = 8'h08;
    localparam logic [7:0] CNT_FAULT_BITS = 8'h0F;

    // module-wide output fault mask bits
    localparam logic [15:0] MOD_FAULT_SECTION = 16'h0001;
    localparam logic [15:0] MOD_FAULT_SWITCH1 = 16'h0002;
    localparam logic [15:0] MOD_FAULT_SWITCH2 = 16'h0004;
    localparam logic [15:0] MOD_FAULT_PATTERN = 16'h0008;
    localparam logic [15:0] MOD_FAULT_READBACK = 16'h0010;
    localparam logic [15:0] MOD_FAULT_SWITCH_OFF = 16'h0020;
    localparam logic [15:0] MOD_FAULT_CHIP_SELECT = 16'h0100;
    localparam logic [15:0] MOD_FAULT_OVERCURRENT = 16'h0200;
    localparam logic [15:0] MOD_FAULT_TEMP1 = 16'h0400;
    localparam logic [15:0] MOD_FAULT_TEMP2 = 16'h0800;
    localparam logic [15:0] MOD_FAULT_UNDERVOLT = 16'h1000;
    localparam logic [15:0] MOD_FAULT_SWITCH_STATE = 16'h2000;
    localparam logic [15:0] MOD_FAULT_BITS = 16'h3F3F;
    localparam int MOD_OVERCURRENT_BIT = 9;

    // per-output fault mask bits
    localparam logic [7:0] CH_FAULT_CHANNEL = 8'h01;
    localparam logic [7:0] CH_FAULT_OVERCURRENT = 8'h02;
    localparam logic [7:0] CH_FAULT_READBACK = 8'h04;
    localparam logic [7:0] CH_FAULT_INIT = 8'h08;
    localparam logic [7:0] CH_FAULT_BITS = 8'h0F;
    localparam int CH_OVERCURRENT_BIT = 1;

    // interrupt status bits
    localparam int IRQ_W = 7;
    localparam int IRQ_COUNT_OVF_LSB = 0;
    localparam int IRQ_STAMP_OVF_LSB = 2;
    localparam int IRQ_CNT_FAULT_BIT = 4;
    localparam int IRQ_MOD_FAULT_BIT = 5;
    localparam int IRQ_CH_FAULT_BIT = 6;

    // reset values
    localparam logic [3:0] OUT_VALUE_RESET = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 7'h00;
    localparam logic [1:0] AUTO_DIR_RESET = 2'h0;
    localparam logic [1:0] MANUAL_DIR_RESET = 2'h0;

    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STAMP_RES_NS = 1000;
    localparam int STAMP_TICK_CYCLES = (STAMP_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== design/counter_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface counter_link_if;
    logic auto_dir;
    logic manual_dir;
    logic snapshot;
    logic in_a;
    logic in_b;
    logic [counter_status_pkg::COUNT_W-1:0] count;
    logic [counter_status_pkg::COUNT_W-1:0] stamp;
    logic count_ovf;
    logic stamp_ovf;

    modport chan (
        input auto_dir, manual_dir, snapshot, in_a, in_b,
        output count, stamp, count_ovf, stamp_ovf
    );
    modport top (
        output auto_dir, manual_dir, snapshot, in_a, in_b,
        input count, stamp, count_ovf, stamp_ovf
    );
endinterface
`default_nettype wire

// ===== design/counter_channel.sv
`timescale 1ns/1ns
`default_nettype none
module counter_channel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link to the status block
    counter_link_if.chan link
);
    localparam int W = counter_status_pkg::COUNT_W;
    localparam logic [W-1:0] MAX_VALUE = 24'hFFFFFF;
    localparam logic [W-1:0] ZERO_VALUE = 24'h000000;
    localparam logic [7:0] TICK_LAST = 8'(counter_status_pkg::STAMP_TICK_CYCLES - 1);

    logic prev_a;
    logic [7:0] tick_cnt;
    logic [W-1:0] timebase;
    logic [W-1:0] count_live;
    logic [W-1:0] stamp_live;
    logic count_wrap_seen;
    logic stamp_wrap_seen;
    logic step;
    logic down;
    logic us_tick;
    logic count_wrap;
    logic stamp_wrap;

    assign step = link.in_a && !prev_a;
    // automatic mode takes the direction from the second track
    assign down = link.auto_dir ? link.in_b : link.manual_dir;
    assign us_tick = (tick_cnt == TICK_LAST);
    assign count_wrap = step && (down ? (count_live == ZERO_VALUE) : (count_live == MAX_VALUE));
    assign stamp_wrap = us_tick && (timebase == MAX_VALUE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_a <= 1'b0;
        end else begin
            prev_a <= link.in_a;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 8'h00;
            timebase <= ZERO_VALUE;
        end else if (us_tick) begin
            tick_cnt <= 8'h00;
            timebase <= timebase + 24'h000001;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_live <= ZERO_VALUE;
            stamp_live <= ZERO_VALUE;
        end else if (step) begin
            count_live <= down ? count_live - 24'h000001 : count_live + 24'h000001;
            stamp_live <= timebase;
        end
    end

    // wraps since the previous controller cycle; a wrap in the snapshot cycle starts the next window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_wrap_seen <= 1'b0;
            stamp_wrap_seen <= 1'b0;
        end else if (link.snapshot) begin
            count_wrap_seen <= count_wrap;
            stamp_wrap_seen <= stamp_wrap;
        end else begin
            count_wrap_seen <= count_wrap_seen || count_wrap;
            stamp_wrap_seen <= stamp_wrap_seen || stamp_wrap;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.count <= ZERO_VALUE;
            link.stamp <= ZERO_VALUE;
            link.count_ovf <= 1'b0;
            link.stamp_ovf <= 1'b0;
        end else if (link.snapshot) begin
            link.count <= count_live;
            link.stamp <= stamp_live;
            link.count_ovf <= !link.auto_dir && (count_wrap_seen || count_wrap);
            link.stamp_ovf <= stamp_wrap_seen || stamp_wrap;
        end
    end
endmodule
`default_nettype wire

// ===== bench/counter_status_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module counter_status_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [counter_status_pkg::ADDR_W-1:0] paddr,
    input wire logic [counter_status_pkg::DATA_W-1:0] pwdata,
    input wire logic [counter_status_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic [1:0] cnt_a,
    input wire logic [1:0] cnt_b,
    input wire logic [7:0] counter_fault_in,
    input wire logic [15:0] module_fault_in,
    input wire logic [15:0] channel_fault_in,
    input wire logic [3:0] out_drive,
    input wire logic irq
);
    logic [3:0] drive_val;
    logic [6:0] irq_en;
    wire wr = psel && penable && pready && pwrite;
    // shadow copies of what software last wrote
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_val <= 4'h0;
            irq_en <= 7'h00;
        end else if (wr && paddr == counter_status_pkg::OUT_VALUE_OFS) begin
            drive_val <= pwdata[3:0];
        end else if (wr && paddr == counter_status_pkg::IRQ_ENABLE_OFS) begin
            irq_en <= pwdata[6:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h30 |=> pslverr)
        else $error("unmapped address accepted");
    overcurrent_off_a: assert property (module_fault_in[9] [*4] |-> out_drive == 4'h0)
        else $error("outputs on during total overcurrent");
    channel_ovc_off_a: assert property (channel_fault_in[5] [*4] |-> !out_drive[1])
        else $error("output on during its overcurrent");
    drive_follows_a: assert property (($stable(drive_val) && module_fault_in == 16'h0
        && channel_fault_in == 16'h0) [*5] |-> out_drive == drive_val)
        else $error("output differs from written value");
    no_spurious_drive_a: assert property ((out_drive & ~drive_val & ~$past(drive_val)
        & ~$past(drive_val, 2)) == 4'h0)
        else $error("output on without software value");
    irq_needs_enable_a: assert property (irq |-> (irq_en | $past(irq_en)) != 7'h00)
        else $error("interrupt with nothing enabled");
endmodule
bind counter_status_top counter_status_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cnt_a(cnt_a), .cnt_b(cnt_b),
    .counter_fault_in(counter_fault_in), .module_fault_in(module_fault_in),
    .channel_fault_in(channel_fault_in), .out_drive(out_drive), .irq(irq));
`default_nettype wire

// ===== bench/pulse_source.sv
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
    // clock
    input wire logic pclk,
    // encoder tracks
    output logic [1:0] cnt_a,
    output logic [1:0] cnt_b
);
    initial begin
        cnt_a = 2'b00;
        cnt_b = 2'b00;
    end
    // track b settles before a rises so the sensed direction is clean
    task automatic pulse(input int ch, input logic b, input int n);
        repeat (n) begin
            @(posedge pclk);
            cnt_b[ch] <= b;
            repeat (2) @(posedge pclk);
            cnt_a[ch] <= 1'b1;
            repeat (3) @(posedge pclk);
            cnt_a[ch] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [counter_status_pkg::ADDR_W-1:0] paddr;
    logic [counter_status_pkg::DATA_W-1:0] pwdata;
    logic [counter_status_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] cnt_a;
    logic [1:0] cnt_b;
    logic [7:0] counter_fault_in;
    logic [15:0] module_fault_in;
    logic [15:0] channel_fault_in;
    logic [3:0] out_drive;
    logic irq;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h57;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    logic [2:0] ev = 3'h0;

    counter_status_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cnt_a(cnt_a), .cnt_b(cnt_b), .counter_fault_in(counter_fault_in),
        .module_fault_in(module_fault_in), .channel_fault_in(channel_fault_in),
        .out_drive(out_drive), .irq(irq));
    pulse_source src (.pclk(pclk), .cnt_a(cnt_a), .cnt_b(cnt_b));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // controller cycle: latch counts, flags and masks
    task automatic snap(input logic [31:0] ctrl);
        wr(8'h00, ctrl | 32'h1);
        repeat (3) @(posedge pclk);
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // read answers are compared in the order they were requested
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end
    // clock edges since reset release, the time base of the stamp
    always @(posedge pclk) begin
        cyc <= presetn ? cyc + 1 : 0;
    end
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #(40 * 20000);
        n_mismatch++;
        finish_test();
    end
    initial begin
        logic [31:0] r;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        counter_fault_in = 8'h00;
        module_fault_in = 16'h0;
        channel_fault_in = 16'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h10, 33'h0);
        rd(8'h04, 33'h0);
        rd(8'h34, 33'h1_0000_0000);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, 33'h0);
        end_test("registers");
        for (int i = 0; i < 3; i++) begin
            r = xs();
            counter_fault_in <= r[7:0];
            module_fault_in <= r[23:8];
            channel_fault_in <= r[31:16];
            repeat (4) @(posedge pclk);
            snap(32'h0);
            rd(8'h24, {17'h0, 4'h0, r[7:4], 4'h0, r[3:0]});
            rd(8'h2C, {17'h0, r[23:8] & 16'h3F3F});
            rd(8'h30, {5'h0, r[31:28], 4'h0, r[27:24], 4'h0, r[23:20], 4'h0, r[19:16]});
            ev = ev | {|r[31:16], |(r[23:8] & 16'h3F3F), |r[7:0]};
        end
        rd(8'h08, {26'h0, ev, 4'h0});
        end_test("fault masks");
        counter_fault_in <= 8'h00;
        module_fault_in <= 16'h0;
        channel_fault_in <= 16'h0;
        r = xs();
        wr(8'h04, {28'h0, r[3:0]});
        repeat (5) @(posedge pclk);
        check({29'h0, out_drive}, {29'h0, r[3:0]});
        channel_fault_in <= 16'h0020;
        repeat (5) @(posedge pclk);
        check({29'h0, out_drive}, {29'h0, r[3:0] & 4'hD});
        module_fault_in <= 16'h0200;
        repeat (5) @(posedge pclk);
        check({29'h0, out_drive}, 33'h0);
        module_fault_in <= 16'h0;
        channel_fault_in <= 16'h0;
        wr(8'h04, 32'hF);
        repeat (5) @(posedge pclk);
        check({29'h0, out_drive}, 33'hF);
        end_test("outputs");
        snap(32'h10);
        wr(8'h0C, 32'h7F);
        wr(8'h10, 32'h02);
        src.pulse(0, 1'b0, 3);
        src.pulse(1, 1'b0, 1);
        repeat (6) @(posedge pclk);
        snap(32'h10);
        rd(8'h14, 33'h3);
        rd(8'h18, 33'hFF_FFFF);
        rd(8'h28, 33'h2);
        check({32'h0, irq}, 33'h1);
        check({29'h0, out_drive}, 33'hF);
        wr(8'h10, 32'h0);
        repeat (2) @(posedge pclk);
        check({32'h0, irq}, 33'h0);
        rd(8'h08, 33'h2);
        wr(8'h0C, 32'h02);
        rd(8'h08, 33'h0);
        snap(32'h10);
        rd(8'h28, 33'h0);
        end_test("manual counting");
        snap(32'h14);
        src.pulse(1, 1'b1, 1);
        src.pulse(1, 1'b0, 3);
        // last step is taken three edges after its rise, three before this point
        r = cyc;
        repeat (6) @(posedge pclk);
        snap(32'h14);
        rd(8'h00, 33'h14);
        rd(8'h18, 33'h1);
        rd(8'h20, {9'h0, 24'((r - 32'h3) / counter_status_pkg::STAMP_TICK_CYCLES)});
        rd(8'h14, 33'h3);
        rd(8'h28, 33'h0);
        end_test("auto direction");
        finish_test();
    end
endmodule
`default_nettype wire
